/* File: hwmsc_params.svh */
// constants for the hardware mode and strap configuration block
`ifndef HWMSC_PARAMS_SVH
`define HWMSC_PARAMS_SVH
// least hold of the block-start input, in encoder clocks
`define HWMSC_SYNC_MIN_CLKS 3
`define HWMSC_SYNC_CNT_W 2
// sub-frames per channel status block (192 frames, two sub-frames each)
`define HWMSC_SUBFRAMES_PER_BLOCK 384
`define HWMSC_SF_CNT_W 9
// output format resolution field values: 24-bit, 16-bit, direct
`define HWMSC_RES_24 2'h0
`define HWMSC_RES_16 2'h2
`define HWMSC_RES_DIRECT 2'h3
// start-up format straps
`define HWMSC_FMT_SEL_W 2
`endif

/* File: hwmsc_pkg.sv */
// types for the hardware mode and strap configuration block
package hwmsc_pkg;
  typedef enum logic [2:0] {
    HWMSC_SOFTWARE,
    HWMSC_MODE1,
    HWMSC_MODE2,
    HWMSC_MODE3,
    HWMSC_MODE4,
    HWMSC_MODE5,
    HWMSC_MODE6
  } hwmsc_mode_e;

  typedef enum logic {
    HWMSC_CTRL_TWO_WIRE,
    HWMSC_CTRL_SERIAL
  } hwmsc_ctrl_e;

  typedef struct packed {
    logic       special;
    logic [1:0] resolution;
    logic       justify;
    logic       msb_delay;
    logic       bitclk_pol;
    logic       frame_pol;
  } hwmsc_fmt_s;
endpackage

/* File: hwmsc_top.sv */
// start-up strap capture, mode decode and small pin control for the transceiver
`timescale 1ns/1ns
`default_nettype none
`include "hwmsc_params.svh"

// Contract
// - flag low only for 50/15 emphasis
// - emphasis strap sets slave address bit 2
// - sync output high first sub-frame only
// - sync input held three clocks restarts block
// - line outputs low during reset
// - chip-select falling edge selects serial mode
// - address pins or serial data input
// - data pin open-drain or serial output
// - user pin input by default, else output
// - select pin high gives hardware mode
// - equal flow selects plus source pick mode
// - unequal flow selects give transceive modes
// - straps pick master, format, sync direction
// - left and 24-bit i2s output fields
// - right justified only as master
// - 16-bit i2s and direct output fields
// - left and i2s input fields
// - right justified 24 and 16 input
// - frame clock toggles at output rate as master only
// - reset clears all state, low power; preemph_flag and ctrl_data_rx reset high instead
module hwmsc_top (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset,
  // straps and mode pins
  input  wire logic                          hw_select,
  input  wire logic                          flow_select0,
  input  wire logic                          flow_select1,
  input  wire logic                          source_serial,
  input  wire logic                          strap_out_master,
  input  wire logic [`HWMSC_FMT_SEL_W-1:0]   strap_out_fmt,
  input  wire logic                          strap_out_direct,
  input  wire logic [`HWMSC_FMT_SEL_W-1:0]   strap_in_fmt,
  input  wire logic                          strap_sync_out,
  // received channel status emphasis
  input  wire logic                          rx_preemph_flag_5015,
  // pre-emphasis pin, strap at start-up then flag
  input  wire logic                          preemph_in,
  output logic                               preemph_flag,
  output logic                               preemph_oe,
  output logic                               slave_addr_bit2,
  // control port pins
  input  wire logic                          slave_addr_bit0,
  input  wire logic                          slave_addr_bit1,
  input  wire logic                          ctrl_read_data,
  input  wire logic                          sda_drive_low,
  input  wire logic                          sda_in,
  output logic                               ctrl_mode_serial,
  output logic                               ctrl_port_enable,
  output logic [1:0]                         addr_bits_low,
  output logic                               ctrl_serial_in,
  output logic                               ctrl_data_rx,
  output logic                               ctrl_serial_out,
  output logic                               ctrl_data_oe,
  // transmit sub-frame timing and block sync pin
  input  wire logic                          tx_subframe_start,
  input  wire logic                          sync_pin_in,
  output logic                               block_start_sync,
  output logic                               sync_oe,
  output logic                               tx_block_first,
  // line drivers
  input  wire logic                          tx_line_pos,
  input  wire logic                          tx_line_neg,
  output logic                               line_drive_pos,
  output logic                               line_drive_neg,
  // user-bit pin
  input  wire logic                          user_pin_direction,
  input  wire logic                          rx_user_bit,
  input  wire logic                          user_pin_in,
  output logic                               user_pin_out,
  output logic                               user_pin_oe,
  output logic                               tx_user_bit,
  // output serial frame clock
  input  wire logic                          out_sample_tick,
  output logic                               out_frame_clk,
  // decoded configuration
  output hwmsc_pkg::hwmsc_mode_e             hw_mode,
  output logic                               out_master,
  output hwmsc_pkg::hwmsc_fmt_s              out_fmt,
  output hwmsc_pkg::hwmsc_fmt_s              in_fmt
);

  function automatic hwmsc_pkg::hwmsc_mode_e decode_mode(input logic hs, input logic f1,
                                                         input logic f0, input logic src);
    decode_mode = hwmsc_pkg::HWMSC_SOFTWARE;
    if (hs) begin
      unique case ({f1, f0})
        2'h0: decode_mode = src ? hwmsc_pkg::HWMSC_MODE2 : hwmsc_pkg::HWMSC_MODE1;
        2'h1: decode_mode = hwmsc_pkg::HWMSC_MODE3;
        2'h2: decode_mode = hwmsc_pkg::HWMSC_MODE4;
        2'h3: decode_mode = src ? hwmsc_pkg::HWMSC_MODE6 : hwmsc_pkg::HWMSC_MODE5;
      endcase
    end
  endfunction

  function automatic hwmsc_pkg::hwmsc_fmt_s out_format(input logic [1:0] sel, input logic direct,
                                                       input logic master);
    out_format = '{1'b0, `HWMSC_RES_24, 1'b0, 1'b0, 1'b1, 1'b0};
    if (direct) begin
      out_format = '{1'b0, `HWMSC_RES_DIRECT, 1'b0, 1'b0, 1'b1, 1'b0};
    end else begin
      unique case (sel)
        2'h0: out_format = '{1'b0, `HWMSC_RES_24, 1'b0, 1'b0, 1'b1, 1'b0};
        2'h1: out_format = '{1'b0, `HWMSC_RES_24, 1'b0, 1'b1, 1'b0, 1'b1};
        2'h2: if (master) begin
          out_format = '{1'b0, `HWMSC_RES_24, 1'b1, 1'b0, 1'b0, 1'b0};
        end
        2'h3: out_format = '{1'b0, `HWMSC_RES_16, 1'b0, 1'b1, 1'b0, 1'b1};
      endcase
    end
  endfunction

  function automatic hwmsc_pkg::hwmsc_fmt_s in_format(input logic [1:0] sel);
    in_format = '{1'b0, `HWMSC_RES_24, 1'b0, 1'b0, 1'b1, 1'b0};
    unique case (sel)
      2'h0: in_format = '{1'b0, `HWMSC_RES_24, 1'b0, 1'b0, 1'b1, 1'b0};
      2'h1: in_format = '{1'b0, `HWMSC_RES_24, 1'b0, 1'b1, 1'b0, 1'b1};
      2'h2: in_format = '{1'b0, `HWMSC_RES_24, 1'b1, 1'b0, 1'b0, 1'b0};
      2'h3: in_format = '{1'b0, `HWMSC_RES_16, 1'b1, 1'b0, 1'b0, 1'b0};
    endcase
  endfunction

  logic                         captured_r;
  logic                         sync_is_out_r;
  logic                         cs_prev_r;
  logic                         serial_r;
  logic [`HWMSC_SYNC_CNT_W-1:0] sync_cnt_r;
  logic                         sync_req_r;
  logic [`HWMSC_SF_CNT_W-1:0]   sf_cnt_r;

  // strap capture, one cycle after release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      captured_r      <= 1'b0;
      slave_addr_bit2 <= 1'b0;
      hw_mode         <= hwmsc_pkg::HWMSC_SOFTWARE;
      out_master      <= 1'b0;
      out_fmt         <= '0;
      in_fmt          <= '0;
      sync_is_out_r   <= 1'b0;
    end else if (!captured_r) begin
      captured_r      <= 1'b1;
      slave_addr_bit2 <= preemph_in;
      hw_mode         <= decode_mode(hw_select, flow_select1, flow_select0, source_serial);
      out_master      <= strap_out_master;
      out_fmt         <= out_format(strap_out_fmt, strap_out_direct, strap_out_master);
      in_fmt          <= in_format(strap_in_fmt);
      sync_is_out_r   <= strap_sync_out;
    end
  end

  // pre-emphasis flag, pin released during capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      preemph_flag <= 1'b1;
      preemph_oe   <= 1'b0;
    end else begin
      preemph_flag <= !rx_preemph_flag_5015;
      preemph_oe   <= captured_r;
    end
  end

  // control port select
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // low after reset, so an address strap tied low is never taken for an edge
      cs_prev_r <= 1'b0;
      serial_r  <= 1'b0;
    end else begin
      cs_prev_r <= slave_addr_bit0;
      if (cs_prev_r && !slave_addr_bit0) begin
        serial_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_mode_serial <= 1'b0;
      ctrl_port_enable <= 1'b0;
      addr_bits_low    <= 2'h0;
      ctrl_serial_in   <= 1'b0;
      ctrl_data_rx     <= 1'b1;
      ctrl_serial_out  <= 1'b0;
      ctrl_data_oe     <= 1'b0;
    end else begin
      ctrl_mode_serial <= serial_r;
      ctrl_port_enable <= serial_r ? !slave_addr_bit0 : 1'b1;
      addr_bits_low    <= serial_r ? 2'h0 : {slave_addr_bit1, slave_addr_bit0};
      ctrl_serial_in   <= serial_r ? slave_addr_bit1 : 1'b0;
      ctrl_data_rx     <= serial_r ? 1'b1 : sda_in;
      ctrl_serial_out  <= serial_r ? ctrl_read_data : 1'b0;
      ctrl_data_oe     <= serial_r ? !slave_addr_bit0 : sda_drive_low;
    end
  end

  // block-start input hold counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_cnt_r <= '0;
      sync_req_r <= 1'b0;
    end else begin
      if (sync_is_out_r || !sync_pin_in) begin
        sync_cnt_r <= '0;
      end else if (sync_cnt_r != `HWMSC_SYNC_CNT_W'(`HWMSC_SYNC_MIN_CLKS - 1)) begin
        sync_cnt_r <= sync_cnt_r + 1'b1;
      end else begin
        sync_req_r <= 1'b1;
      end
      if (tx_subframe_start && !(sync_cnt_r == `HWMSC_SYNC_CNT_W'(`HWMSC_SYNC_MIN_CLKS - 1)
                                 && sync_pin_in && !sync_is_out_r)) begin
        sync_req_r <= 1'b0;
      end
    end
  end

  // sub-frame position within channel status block
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sf_cnt_r       <= '0;
      tx_block_first <= 1'b0;
    end else if (tx_subframe_start) begin
      if (sync_req_r || sf_cnt_r == `HWMSC_SF_CNT_W'(`HWMSC_SUBFRAMES_PER_BLOCK - 1)) begin
        sf_cnt_r       <= '0;
        tx_block_first <= 1'b1;
      end else begin
        sf_cnt_r       <= sf_cnt_r + 1'b1;
        tx_block_first <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      block_start_sync <= 1'b0;
      sync_oe          <= 1'b0;
    end else begin
      block_start_sync <= sync_is_out_r && tx_block_first;
      sync_oe          <= sync_is_out_r;
    end
  end

  // line drivers held low under reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      line_drive_pos <= 1'b0;
      line_drive_neg <= 1'b0;
    end else begin
      line_drive_pos <= tx_line_pos;
      line_drive_neg <= tx_line_neg;
    end
  end

  // user-bit pin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      user_pin_oe  <= 1'b0;
      user_pin_out <= 1'b0;
      tx_user_bit  <= 1'b0;
    end else begin
      user_pin_oe  <= user_pin_direction;
      user_pin_out <= user_pin_direction ? rx_user_bit : 1'b0;
      tx_user_bit  <= user_pin_direction ? 1'b0 : user_pin_in;
    end
  end

  // frame clock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_frame_clk <= 1'b0;
    end else if (out_sample_tick && out_master) begin
      out_frame_clk <= !out_frame_clk;
    end
  end

  // checks
  // block-start input seen high on three clocks in a row
  sequence sync_held_s;
    (sync_pin_in && !sync_is_out_r) [*3];
  endsequence

  // a pending block-start request meets a sub-frame start
  sequence sync_served_s;
    sync_req_r && tx_subframe_start;
  endsequence

  flag_follows_preemph_flag_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> preemph_flag == !$past(rx_preemph_flag_5015)) else $error("emphasis flag wrong");
  addr_bit2_take_a: assert property (@(posedge clk) disable iff (reset)
    $rose(captured_r) |-> slave_addr_bit2 == $past(preemph_in)) else $error("address bit not taken");
  addr_bit2_hold_a: assert property (@(posedge clk) disable iff (reset)
    captured_r && $past(captured_r) |-> $stable(slave_addr_bit2)) else $error("address bit moved");
  sync_out_first_a: assert property (@(posedge clk) disable iff (reset)
    block_start_sync |-> $past(tx_block_first) && $past(sync_is_out_r)) else $error("sync out wrong");
  block_wrap_a: assert property (@(posedge clk) disable iff (reset)
    tx_subframe_start && sf_cnt_r == `HWMSC_SF_CNT_W'(`HWMSC_SUBFRAMES_PER_BLOCK - 1) |=> tx_block_first)
    else $error("block did not wrap");
  sync_in_restart_a: assert property (@(posedge clk) disable iff (reset)
    sync_held_s |=> sync_req_r) else $error("sync request missing");
  sync_served_a: assert property (@(posedge clk) disable iff (reset)
    sync_served_s |=> tx_block_first && sf_cnt_r == '0) else $error("sync request not served");
  line_low_a: assert property (@(posedge clk)
    reset |-> !line_drive_pos && !line_drive_neg) else $error("line not low in reset");
  serial_entry_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) && $fell(slave_addr_bit0) |=> ##1 ctrl_mode_serial) else $error("serial mode not entered");
  serial_sticky_a: assert property (@(posedge clk) disable iff (reset)
    ctrl_mode_serial |=> ctrl_mode_serial) else $error("serial mode lost");
  port_enable_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) && $past(serial_r) |-> ctrl_port_enable == !$past(slave_addr_bit0)) else $error("port enable");
  addr_route_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) && !$past(serial_r) |-> addr_bits_low == {$past(slave_addr_bit1), $past(slave_addr_bit0)}
    && !ctrl_serial_in) else $error("address routing");
  serial_in_route_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) && $past(serial_r) |-> ctrl_serial_in == $past(slave_addr_bit1))
    else $error("serial data in routing");
  data_out_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) && $past(serial_r) |-> ctrl_serial_out == $past(ctrl_read_data)
    && ctrl_data_oe == !$past(slave_addr_bit0)) else $error("serial data out wrong");
  open_drain_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) && !$past(serial_r) |-> ctrl_data_oe == $past(sda_drive_low)
    && ctrl_data_rx == $past(sda_in)) else $error("open drain data wrong");
  user_dir_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> user_pin_oe == $past(user_pin_direction)) else $error("user pin direction");
  mode_soft_a: assert property (@(posedge clk) disable iff (reset)
    $rose(captured_r) && !$past(hw_select) |-> hw_mode == hwmsc_pkg::HWMSC_SOFTWARE) else $error("mode not software");
  mode_unequal_a: assert property (@(posedge clk) disable iff (reset)
    $rose(captured_r) && $past(hw_select) && ($past(flow_select1) != $past(flow_select0)) |->
    hw_mode == ($past(flow_select0) ? hwmsc_pkg::HWMSC_MODE3 : hwmsc_pkg::HWMSC_MODE4)) else $error("transceive mode");
  mode_hold_a: assert property (@(posedge clk) disable iff (reset)
    captured_r && $past(captured_r) |-> $stable(hw_mode) && $stable(out_fmt) && $stable(in_fmt)
    && $stable(out_master)) else $error("decoded settings moved");
  frame_toggle_a: assert property (@(posedge clk) disable iff (reset)
    $past(out_sample_tick) && $past(out_master) |-> out_frame_clk != $past(out_frame_clk))
    else $error("frame clock stuck");
  frame_idle_a: assert property (@(posedge clk) disable iff (reset)
    !$past(out_sample_tick) |-> $stable(out_frame_clk)) else $error("frame clock moved");

endmodule
`default_nettype wire

/* File: hwmsc_far_model.sv */
// far-side model: host data line, block-start driver and user pin wire
`timescale 1ns/1ns
`default_nettype none
module hwmsc_far_model (
  // clock and host controls
  input  wire logic       clk,
  input  wire logic       sync_go,
  input  wire logic [1:0] sync_len,
  input  wire logic       host_sda_low,
  input  wire logic       host_user,
  // device pins
  input  wire logic       ctrl_data_oe,
  input  wire logic       ctrl_mode_serial,
  input  wire logic       ctrl_serial_out,
  input  wire logic       sync_oe,
  input  wire logic       block_start_sync,
  input  wire logic       user_pin_oe,
  input  wire logic       user_pin_out,
  output logic            sda_in,
  output logic            sync_pin_in,
  output logic            user_pin_in
);
  logic [1:0] left_r = 2'h0;
  // hold the block-start line high for the asked number of clocks
  always @(posedge clk) begin
    if (sync_go)
      left_r <= sync_len;
    else if (left_r != 2'h0)
      left_r <= left_r - 2'h1;
  end
  // open drain with pull-up; in serial mode the device drives the level
  assign sda_in = ctrl_data_oe ? (ctrl_mode_serial & ctrl_serial_out) : !host_sda_low;
  assign sync_pin_in = sync_oe ? block_start_sync : (left_r != 2'h0);
  assign user_pin_in = user_pin_oe ? user_pin_out : host_user;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the strap, mode and pin control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk, reset, hw_select, flow_select0, flow_select1, source_serial, strap_out_master;
  logic strap_out_direct, strap_sync_out, rx_preemph_flag_5015, preemph_in, slave_addr_bit0, slave_addr_bit1;
  logic ctrl_read_data, sda_drive_low, sda_in, tx_subframe_start, sync_pin_in, tx_line_pos, tx_line_neg;
  logic user_pin_direction, rx_user_bit, user_pin_in, out_sample_tick, sync_go, host_sda_low, host_user;
  logic [1:0] strap_out_fmt, strap_in_fmt, addr_bits_low, sync_len;
  logic preemph_flag, preemph_oe, slave_addr_bit2, ctrl_mode_serial, ctrl_port_enable, ctrl_serial_in;
  logic ctrl_data_rx, ctrl_serial_out, ctrl_data_oe, block_start_sync, sync_oe, tx_block_first;
  logic line_drive_pos, line_drive_neg, user_pin_out, user_pin_oe, tx_user_bit, out_frame_clk, out_master;
  hwmsc_pkg::hwmsc_mode_e hw_mode;
  hwmsc_pkg::hwmsc_fmt_s  out_fmt, in_fmt;
  logic [31:0] seed, r;
  logic [10:0] st;
  logic [7:0]  cnt;
  logic        f, b, pre;
  logic [6:0]  out_tab [4] = '{7'h02, 7'h05, 7'h08, 7'h25};
  logic [6:0]  in_tab [4] = '{7'h02, 7'h05, 7'h08, 7'h28};
  int fails = 0, n_checks = 0, cyc = 0;

  hwmsc_top u_dut (.clk, .reset, .hw_select, .flow_select0, .flow_select1, .source_serial, .strap_out_master,
    .strap_out_fmt, .strap_out_direct, .strap_in_fmt, .strap_sync_out, .rx_preemph_flag_5015, .preemph_in, .preemph_flag,
    .preemph_oe, .slave_addr_bit2, .slave_addr_bit0, .slave_addr_bit1, .ctrl_read_data, .sda_drive_low, .sda_in,
    .ctrl_mode_serial, .ctrl_port_enable, .addr_bits_low, .ctrl_serial_in, .ctrl_data_rx, .ctrl_serial_out,
    .ctrl_data_oe, .tx_subframe_start, .sync_pin_in, .block_start_sync, .sync_oe, .tx_block_first, .tx_line_pos,
    .tx_line_neg, .line_drive_pos, .line_drive_neg, .user_pin_direction, .rx_user_bit, .user_pin_in,
    .user_pin_out, .user_pin_oe, .tx_user_bit, .out_sample_tick, .out_frame_clk, .hw_mode, .out_master,
    .out_fmt, .in_fmt);
  hwmsc_far_model u_far (.clk, .sync_go, .sync_len, .host_sda_low, .host_user, .ctrl_data_oe, .ctrl_mode_serial,
    .ctrl_serial_out, .sync_oe, .block_start_sync, .user_pin_oe, .user_pin_out, .sda_in, .sync_pin_in,
    .user_pin_in);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed[0] ? ((seed >> 1) ^ 32'h80200003) : (seed >> 1);
    return seed;
  endfunction

  function automatic logic [2:0] exp_mode(input logic [10:0] s);
    if (!s[10])
      return hwmsc_pkg::HWMSC_SOFTWARE;
    case (s[9:8])
      2'h0: return s[7] ? hwmsc_pkg::HWMSC_MODE2 : hwmsc_pkg::HWMSC_MODE1;
      2'h1: return hwmsc_pkg::HWMSC_MODE3;
      2'h2: return hwmsc_pkg::HWMSC_MODE4;
      default: return s[7] ? hwmsc_pkg::HWMSC_MODE6 : hwmsc_pkg::HWMSC_MODE5;
    endcase
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic straps(input logic [10:0] s);
    {hw_select, flow_select1, flow_select0, source_serial, strap_out_master, strap_out_fmt, strap_out_direct,
      strap_in_fmt, preemph_in} = s;
  endtask

  task automatic rst(input logic [10:0] s, input logic so);
    reset = 1'b1;
    straps(s);
    strap_sync_out = so;
    tx_line_pos = 1'b1;
    tx_line_neg = 1'b1;
    step(2);
    chk(line_drive_pos, 0);
    chk(line_drive_neg, 0);
    chk(preemph_flag, 1);
    chk(preemph_oe, 0);
    step(2);
    reset = 1'b0;
    step(3);
  endtask

  // one sub-frame of four clocks; reports first-of-block and the sync pin late in it
  task automatic sub(output logic first, output logic bss);
    first = 1'b0;
    tx_subframe_start = 1'b1;
    for (int k = 0; k < 3; k++) begin
      step(1);
      tx_subframe_start = 1'b0;
      first = first | tx_block_first;
    end
    bss = block_start_sync;
    step(1);
  endtask

  task automatic sync_pulse(input logic [1:0] n);
    sync_len = n;
    sync_go = 1'b1;
    step(1);
    sync_go = 1'b0;
    step(4);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      $display("[FAIL] %0t run too long", $time);
      fails++;
      print_verdict();
    end
  end

  initial begin
    {hw_select, flow_select0, flow_select1, source_serial, strap_out_master, strap_out_direct, strap_sync_out,
      rx_preemph_flag_5015, preemph_in, slave_addr_bit1, ctrl_read_data, sda_drive_low, tx_subframe_start, tx_line_pos,
      tx_line_neg, user_pin_direction, rx_user_bit, out_sample_tick, sync_go, host_sda_low, host_user} = '0;
    {strap_out_fmt, strap_in_fmt, sync_len} = '0;
    slave_addr_bit0 = 1'b1;
    reset = 1'b1;
    seed = 32'hC6F71F18;
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      st = r[10:0];
      if (i < 8) begin
        st[10] = 1'b1;
        st[6:3] = {i[2], i[1:0], 1'b0};
      end
      rst(st, 1'b0);
      straps(~st);
      step(3);
      chk({5'h0, hw_mode}, {5'h0, exp_mode(st)});
      chk(slave_addr_bit2, st[0]);
      chk(line_drive_pos, tx_line_pos);
      chk(line_drive_neg, tx_line_neg);
      chk(preemph_oe, 1);
      if (st[10]) begin
        chk(out_master, st[6]);
        chk(out_fmt, st[3] ? 7'h32 : ((st[5:4] == 2'h2 && !st[6]) ? 7'h02 : out_tab[st[5:4]]));
        chk(in_fmt, in_tab[st[2:1]]);
        if (st[6]) begin
          pre = out_frame_clk;
          out_sample_tick = 1'b1;
          step(1);
          out_sample_tick = 1'b0;
          step(2);
          chk(out_frame_clk, !pre);
        end
      end
    end
    $display("test straps done");
    sda_drive_low = 1'b1;
    step(3);
    chk(ctrl_mode_serial, 0);
    chk(addr_bits_low, 2'h1);
    chk(ctrl_data_oe, 1);
    sda_drive_low = 1'b0;
    host_sda_low = 1'b1;
    step(3);
    chk(ctrl_data_oe, 0);
    chk(ctrl_data_rx, 0);
    slave_addr_bit0 = 1'b0;
    step(3);
    chk(ctrl_mode_serial, 1);
    chk(ctrl_port_enable, 1);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      {slave_addr_bit1, ctrl_read_data} = r[1:0];
      step(2);
      chk(ctrl_serial_in, slave_addr_bit1);
      chk(ctrl_serial_out, ctrl_read_data);
      chk(ctrl_data_oe, 1);
      chk(ctrl_data_rx, 1);
    end
    slave_addr_bit0 = 1'b1;
    step(3);
    chk(ctrl_port_enable, 0);
    chk(ctrl_data_oe, 0);
    chk(ctrl_mode_serial, 1);
    $display("test control port done");
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      {user_pin_direction, rx_user_bit, host_user, rx_preemph_flag_5015} = r[3:0];
      step(3);
      chk(preemph_flag, !rx_preemph_flag_5015);
      chk(user_pin_oe, user_pin_direction);
      chk(user_pin_direction ? user_pin_out : tx_user_bit, user_pin_direction ? rx_user_bit : host_user);
    end
    $display("test pins done");
    for (int i = 0; i < 3; i++)
      sub(f, b);
    sync_pulse(2'h2);
    sub(f, b);
    chk(f, 0);
    sync_pulse(2'h3);
    sub(f, b);
    chk(f, 1);
    rst(11'h400, 1'b1);
    chk(sync_oe, 1);
    cnt = 8'h00;
    for (int i = 0; i < 384; i++) begin
      sub(f, b);
      cnt = cnt + {7'h00, b};
    end
    chk(cnt, 1);
    chk(f, 1);
    $display("test block sync done");
    print_verdict();
  end
endmodule
`default_nettype wire
